/* shared/ddzq_pkg.sv */
package ddzq_pkg;

  // Clock period and time to cycle conversion, rounded up, never below one
  localparam int CLK_NS = 10;

  function automatic int ddzq_ns2ck(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ddzq_ns2ck

  // Analog limits in ns
  localparam int T_RCD_NS = 14;
  localparam int T_RP_NS = 14;
  localparam int T_RAS_NS = 35;
  localparam int T_RC_NS = 49;
  localparam int T_RRD_NS = 8;
  localparam int T_FAW_NS = 40;
  localparam int T_RTP_NS = 8;
  localparam int RCD_CK = ddzq_ns2ck(T_RCD_NS);
  localparam int RP_CK = ddzq_ns2ck(T_RP_NS);
  localparam int RAS_CK = ddzq_ns2ck(T_RAS_NS);
  localparam int RC_CK = ddzq_ns2ck(T_RC_NS);
  localparam int RRD_CK = ddzq_ns2ck(T_RRD_NS);
  localparam int FAW_CK = ddzq_ns2ck(T_FAW_NS);
  localparam int RTP_CK = ddzq_ns2ck(T_RTP_NS);

  // Limits given in clocks
  localparam int CCD_CK = 4;
  localparam int RD2PRE_CK = 4;
  localparam int RD2WR_EXTRA_CK = 2;
  localparam int ZQINIT_CK = 512;
  localparam int ZQOPER_CK = 256;
  localparam int ZQCS_CK = 64;
  localparam int FAW_ACTS = 4;
  localparam int PRE_LAT = 3;

  // Address bits with a command meaning
  localparam int A_AP = 10;
  localparam int A_BC = 12;

  // Register map
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_ERR = 4'h8;
  localparam logic [3:0] REG_ZQN = 4'hC;

  // Configuration fields
  localparam int CFG_W = 14;
  localparam int CFG_CL = 0;
  localparam int CFG_AL = 4;
  localparam int CFG_CWL = 8;
  localparam int CFG_BC4 = 12;
  localparam int CFG_OTF = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 14'h0505;

  // Error flag positions
  localparam int E_NOROW = 0;
  localparam int E_RCD = 1;
  localparam int E_ACT_OPEN = 2;
  localparam int E_RC = 3;
  localparam int E_RRD = 4;
  localparam int E_FAW = 5;
  localparam int E_CCD = 6;
  localparam int E_RD2WR = 7;
  localparam int E_RD2PRE = 8;
  localparam int E_RP = 9;
  localparam int E_ZQ_IDLE = 10;
  localparam int E_ZQ_QUIET = 11;
  localparam int E_ZQ_CKE = 12;
  localparam int E_ZQ_ODT = 13;
  localparam int ERR_W = 14;

  localparam int DQ_W = 8;

  typedef enum logic [2:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_ZQ, OP_OTHER
  } ddzq_op_e;

  typedef struct packed {
    logic cke;
    logic odt;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } ddzq_cmd_s;

  typedef struct packed {
    logic v;
    logic bc4;
    logic [2:0] ba;
    logic [7:0] row;
    logic [9:0] col;
  } ddzq_launch_s;

  typedef struct packed {
    logic dq_oe;
    logic dqs_oe;
    logic dqs_run;
    logic [DQ_W-1:0] dq_rise;
    logic [DQ_W-1:0] dq_fall;
  } ddzq_rdout_s;

  function automatic ddzq_op_e ddzq_decode(input ddzq_cmd_s c);
    ddzq_op_e op;
    case ({c.cs_n, c.ras_n, c.cas_n, c.we_n})
      4'b0111: op = OP_NOP;
      4'b0011: op = OP_ACT;
      4'b0101: op = OP_RD;
      4'b0100: op = OP_WR;
      4'b0010: op = OP_PRE;
      4'b0110: op = OP_ZQ;
      default: op = c.cs_n ? OP_NOP : OP_OTHER;
    endcase
    return op;
  endfunction : ddzq_decode

  // Data element k of a burst; BC4 wraps inside its nibble
  function automatic logic [DQ_W-1:0] ddzq_elem(input ddzq_launch_s s, input logic [2:0] k);
    logic [2:0] c;
    c = s.bc4 ? {s.col[2], s.col[1:0] + k[1:0]} : s.col[2:0] + k;
    return {s.ba, s.col[4:3], c} ^ s.row;
  endfunction : ddzq_elem

endpackage : ddzq_pkg

/* rtl/ddzq_rd_pipe.sv */
`timescale 1ns/1ns
module ddzq_rd_pipe
  import ddzq_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Read launch in, delayed copy out
  input wire ddzq_launch_s launch,
  input wire logic [$clog2(DEPTH)-1:0] tap,
  output ddzq_launch_s tap_out
);

  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_chk
    $error("ddzq_rd_pipe: DEPTH must be a power of two");
  end

  ddzq_launch_s sh_q [DEPTH];

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        sh_q[i] <= '0;
      end
    end else begin
      sh_q[0] <= launch;
      for (int i = 1; i < DEPTH; i++) begin
        sh_q[i] <= sh_q[i-1];
      end
    end
  end

  assign tap_out = sh_q[tap];

endmodule : ddzq_rd_pipe

/* rtl/ddzq_dram.sv */
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
module ddzq_dram
  import ddzq_pkg::*;
#(
  parameter int CT_W = 8,
  parameter int PIPE_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Command and address bus
  input wire ddzq_cmd_s cmd,
  // Read data and strobe
  output ddzq_rdout_s rdout,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int NB = 8;
  localparam int TAP_W = $clog2(PIPE_DEPTH);
  localparam logic [CT_W-1:0] RP_C = CT_W'(RP_CK);
  localparam logic [CT_W-1:0] RC_C = CT_W'(RC_CK);
  localparam logic [CT_W-1:0] RAS_C = CT_W'(RAS_CK);
  localparam logic [CT_W-1:0] RRD_C = CT_W'(RRD_CK);
  localparam logic [CT_W-1:0] FAW_C = CT_W'(FAW_CK);
  localparam logic [CT_W-1:0] CCD_C = CT_W'(CCD_CK);
  localparam logic [CT_W-1:0] AGE_ONE = CT_W'(1);
  localparam int RTPX = (RTP_CK > RD2PRE_CK) ? RTP_CK : RD2PRE_CK;

  if ((CT_W < 7) || (RC_CK >= (1 << CT_W) - 1) || (FAW_CK >= (1 << CT_W) - 1)) begin : g_chk
    $error("ddzq_dram: CT_W too small for the timing limits");
  end
  if (PIPE_DEPTH < 32) begin : g_chk_pipe
    $error("ddzq_dram: PIPE_DEPTH must cover the largest read latency");
  end

  function automatic logic [CT_W-1:0] sat_inc(input logic [CT_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  // Configuration and latencies
  logic [CFG_W-1:0] cfg_q;
  logic [ERR_W-1:0] err_q;
  logic [15:0] zqn_q;
  logic [3:0] cl, al, cwl;
  logic [4:0] rl, wl;
  logic [TAP_W-1:0] rl_tap;
  assign cl = cfg_q[CFG_CL +: 4];
  assign al = cfg_q[CFG_AL +: 4];
  assign cwl = cfg_q[CFG_CWL +: 4];
  assign rl = {1'b0, al} + {1'b0, cl};
  assign wl = {1'b0, al} + {1'b0, cwl};
  assign rl_tap = (rl >= 5'(PRE_LAT)) ? TAP_W'(rl - 5'(PRE_LAT)) : '0;

  // Command decode
  ddzq_op_e op;
  logic is_act, is_rd, is_wr, is_pre, is_zq, is_col, pre_all;
  logic [2:0] b;
  assign op = ddzq_decode(cmd);
  assign is_act = (op == OP_ACT);
  assign is_rd = (op == OP_RD);
  assign is_wr = (op == OP_WR);
  assign is_pre = (op == OP_PRE);
  assign is_zq = (op == OP_ZQ);
  assign is_col = is_rd | is_wr;
  assign pre_all = cmd.addr[A_AP];
  assign b = cmd.ba;

  // Bank state and command ages; an age reads k at the k-th edge after its command
  logic [NB-1:0] open_q, ap_pend_q;
  logic [7:0] row_q [NB];
  logic [CT_W-1:0] act_age_q [NB];
  logic [CT_W-1:0] rd_age_q [NB];
  logic [CT_W-1:0] pre_age_q [NB];
  logic [CT_W-1:0] ap_cnt_q [NB];
  logic [CT_W-1:0] faw_q [FAW_ACTS];
  logic [CT_W-1:0] act_any_q, rd_any_q, wr_any_q;
  logic [9:0] zq_cnt_q;
  logic zq_init_q, zq_busy;
  assign zq_busy = (zq_cnt_q != '0);

  // Derived limits
  logic [CT_W:0] rcd_sum;
  logic [CT_W-1:0] rd2pre_min, ap_load;
  logic [CT_W:0] rd2wr_min;
  logic [NB-1:0] rtp_bad, rp_pend;
  logic rd_go;
  assign rcd_sum = {1'b0, act_age_q[b]} + (CT_W+1)'(al);
  assign rd2pre_min = CT_W'(al) + CT_W'(RTPX);
  assign ap_load = CT_W'(al) + CT_W'(RTPX - 1);
  assign rd2wr_min = (CT_W+1)'(rl) + (CT_W+1)'(CCD_CK + RD2WR_EXTRA_CK) - (CT_W+1)'(wl);
  assign rd_go = is_rd & open_q[b];

  for (genvar g = 0; g < NB; g++) begin : g_bank_chk
    assign rtp_bad[g] = open_q[g] & (rd_age_q[g] < rd2pre_min);
    assign rp_pend[g] = (pre_age_q[g] < RP_C);
  end

  // Protocol checks
  logic [ERR_W-1:0] err_set;
  always_comb begin
    err_set = '0;
    err_set[E_ACT_OPEN] = is_act & (open_q[b] | ap_pend_q[b]);
    err_set[E_RC] = is_act & (act_age_q[b] < RC_C);
    err_set[E_RP] = is_act & rp_pend[b];
    err_set[E_RRD] = is_act & (act_any_q < RRD_C);
    err_set[E_FAW] = is_act & (faw_q[FAW_ACTS-1] < FAW_C);
    err_set[E_NOROW] = is_col & ~open_q[b];
    err_set[E_RCD] = is_col & open_q[b] & (rcd_sum < (CT_W+1)'(RCD_CK));
    err_set[E_CCD] = (is_rd & (rd_any_q < CCD_C)) | (is_wr & (wr_any_q < CCD_C));
    err_set[E_RD2WR] = is_wr & ({1'b0, rd_any_q} < rd2wr_min);
    err_set[E_RD2PRE] = is_pre & (pre_all ? (|rtp_bad) : rtp_bad[b]);
    err_set[E_ZQ_IDLE] = is_zq & ((|(open_q | ap_pend_q)) | (|rp_pend));
    err_set[E_ZQ_QUIET] = zq_busy & ~(op == OP_NOP || is_zq);
    err_set[E_ZQ_CKE] = zq_busy & ~cmd.cke;
    err_set[E_ZQ_ODT] = zq_busy & cmd.odt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      open_q <= '0;
      ap_pend_q <= '0;
      for (int i = 0; i < NB; i++) begin
        row_q[i] <= '0;
        act_age_q[i] <= '1;
        rd_age_q[i] <= '1;
        pre_age_q[i] <= '1;
        ap_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NB; i++) begin
        act_age_q[i] <= sat_inc(act_age_q[i]);
        rd_age_q[i] <= sat_inc(rd_age_q[i]);
        pre_age_q[i] <= sat_inc(pre_age_q[i]);
        if (ap_pend_q[i]) begin
          if (ap_cnt_q[i] != '0) begin
            ap_cnt_q[i] <= ap_cnt_q[i] - 1'b1;
          end else if (act_age_q[i] >= RAS_C) begin
            open_q[i] <= 1'b0;
            ap_pend_q[i] <= 1'b0;
            pre_age_q[i] <= AGE_ONE;
          end
        end
        if (is_pre && (pre_all || (3'(i) == b))) begin
          open_q[i] <= 1'b0;
          ap_pend_q[i] <= 1'b0;
          pre_age_q[i] <= AGE_ONE;
        end
      end
      if (is_act) begin
        open_q[b] <= 1'b1;
        row_q[b] <= cmd.addr[7:0];
        act_age_q[b] <= AGE_ONE;
      end
      if (rd_go) begin
        rd_age_q[b] <= AGE_ONE;
        if (cmd.addr[A_AP]) begin
          ap_pend_q[b] <= 1'b1;
          ap_cnt_q[b] <= ap_load;
        end
      end
    end
  end

  // Channel wide ages and activate window
  always_ff @(posedge clk) begin
    if (srst) begin
      act_any_q <= '1;
      rd_any_q <= '1;
      wr_any_q <= '1;
      for (int i = 0; i < FAW_ACTS; i++) begin
        faw_q[i] <= '1;
      end
    end else begin
      act_any_q <= is_act ? AGE_ONE : sat_inc(act_any_q);
      rd_any_q <= is_rd ? AGE_ONE : sat_inc(rd_any_q);
      wr_any_q <= is_wr ? AGE_ONE : sat_inc(wr_any_q);
      faw_q[0] <= is_act ? AGE_ONE : sat_inc(faw_q[0]);
      for (int i = 1; i < FAW_ACTS; i++) begin
        faw_q[i] <= is_act ? sat_inc(faw_q[i-1]) : sat_inc(faw_q[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zq_cnt_q <= '0;
      zq_init_q <= 1'b0;
      zqn_q <= '0;
    end else if (is_zq) begin
      if (cmd.addr[A_AP]) begin
        zq_cnt_q <= zq_init_q ? 10'(ZQOPER_CK) : 10'(ZQINIT_CK);
        zq_init_q <= 1'b1;
      end else begin
        zq_cnt_q <= 10'(ZQCS_CK);
      end
    end else if (zq_busy) begin
      zq_cnt_q <= zq_cnt_q - 1'b1;
      if (zq_cnt_q == 10'h001) begin
        zqn_q <= zqn_q + 1'b1;
      end
    end
  end

  // Read latency delay line
  ddzq_launch_s launch, tap_out, start_q, cur_q;
  always_comb begin
    launch = '0;
    launch.v = rd_go;
    launch.bc4 = cfg_q[CFG_BC4] | (cfg_q[CFG_OTF] & ~cmd.addr[A_BC]);
    launch.ba = b;
    launch.row = row_q[b];
    launch.col = cmd.addr[9:0];
  end

  ddzq_rd_pipe #(
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .clk(clk),
    .srst(srst),
    .launch(launch),
    .tap(rl_tap),
    .tap_out(tap_out)
  );

  // Burst engine
  logic [1:0] beat_q, left_q, nxt_beat;
  logic go_new, go_cont;
  ddzq_launch_s nxt_src;
  assign go_new = start_q.v;
  assign go_cont = rdout.dq_oe & (left_q != 2'b00);
  assign nxt_beat = go_new ? 2'b00 : beat_q + 2'b01;
  assign nxt_src = go_new ? start_q : cur_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      start_q <= '0;
      cur_q <= '0;
      beat_q <= '0;
      left_q <= '0;
      rdout <= '0;
    end else begin
      start_q <= tap_out;
      if (go_new) begin
        cur_q <= start_q;
        left_q <= start_q.bc4 ? 2'b01 : 2'b11;
      end else if (go_cont) begin
        left_q <= left_q - 2'b01;
      end
      beat_q <= nxt_beat;
      rdout.dq_oe <= go_new | go_cont;
      rdout.dqs_oe <= tap_out.v | go_new | go_cont;
      rdout.dqs_run <= go_new | go_cont;
      rdout.dq_rise <= ddzq_elem(nxt_src, {nxt_beat, 1'b0});
      rdout.dq_fall <= ddzq_elem(nxt_src, {nxt_beat, 1'b1});
    end
  end

  // Register port
  logic hit_cfg, hit_stat, hit_err, hit_zqn;
  logic [31:0] rd_mux;
  logic [ERR_W-1:0] err_clr;
  assign hit_cfg = (reg_addr == REG_CFG);
  assign hit_stat = (reg_addr == REG_STAT);
  assign hit_err = (reg_addr == REG_ERR);
  assign hit_zqn = (reg_addr == REG_ZQN);
  assign err_clr = (reg_wr && hit_err) ? reg_wdata[ERR_W-1:0] : '0;
  assign rd_mux = hit_cfg ? 32'(cfg_q)
                : hit_stat ? 32'({|ap_pend_q, zq_busy, open_q})
                : hit_err ? 32'(err_q)
                : hit_zqn ? 32'(zqn_q)
                : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= CFG_RST;
      err_q <= '0;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && hit_cfg) begin
        cfg_q <= reg_wdata[CFG_W-1:0];
      end
      err_q <= (err_q & ~err_clr) | err_set;
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_pre_then_data;
    rdout.dqs_oe && !rdout.dqs_run |=> rdout.dq_oe && rdout.dqs_run;
  endproperty
  a_pre_then_data: assert property (p_pre_then_data) else $error("preamble not followed by data");

  property p_tap_to_data;
    tap_out.v && !rdout.dq_oe |=> rdout.dqs_oe && !rdout.dq_oe ##1 rdout.dq_oe;
  endproperty
  a_tap_to_data: assert property (p_tap_to_data) else $error("data not one cycle after preamble");

  property p_bl8_len;
    start_q.v && !start_q.bc4 |=> rdout.dq_oe [*4];
  endproperty
  a_bl8_len: assert property (p_bl8_len) else $error("BL8 burst shorter than four clocks");

  property p_bc4_gap;
    start_q.v && start_q.bc4 && !tap_out.v |=> rdout.dq_oe [*2] ##1 !rdout.dq_oe;
  endproperty
  a_bc4_gap: assert property (p_bc4_gap) else $error("chopped burst length wrong");

  property p_float_after;
    rdout.dq_oe && left_q == 2'b00 && !start_q.v |=> !rdout.dq_oe && !rdout.dqs_oe;
  endproperty
  a_float_after: assert property (p_float_after) else $error("bus not released after burst");

  property p_zq_len;
    is_zq && !cmd.addr[A_AP] |=> zq_busy [*8];
  endproperty
  a_zq_len: assert property (p_zq_len) else $error("short calibration ended early");

  property p_ap_hold;
    rd_go && cmd.addr[A_AP] |=> ap_pend_q[$past(b)] [*3];
  endproperty
  a_ap_hold: assert property (p_ap_hold) else $error("auto precharge too early");

  property p_act_opens;
    is_act |=> open_q[$past(b)] && act_age_q[$past(b)] == AGE_ONE;
  endproperty
  a_act_opens: assert property (p_act_opens) else $error("activate did not open bank");

  property p_rcd_flag;
    is_rd && open_q[b] && rcd_sum < (CT_W+1)'(RCD_CK) |=> err_q[E_RCD];
  endproperty
  a_rcd_flag: assert property (p_rcd_flag) else $error("early read not flagged");

  property p_norow_drop;
    is_rd && !open_q[b] |-> !launch.v;
  endproperty
  a_norow_drop: assert property (p_norow_drop) else $error("read to closed bank launched");

  c_seamless: cover property (start_q.v && rdout.dq_oe);
  c_bc4: cover property (start_q.v && start_q.bc4);
  c_zqcl: cover property (is_zq && cmd.addr[A_AP]);
  c_ap_close: cover property ($fell(|ap_pend_q));

endmodule : ddzq_dram

/* dv/ddzq_ctrl_model.sv */
`timescale 1ns/1ns
module ddzq_ctrl_model
  import ddzq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command bus
  output ddzq_cmd_s cmd
);
  initial begin
    cmd = '0;
    cmd.cke = 1'b1;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = 3'b111;
  end

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      {cmd.ras_n, cmd.cas_n, cmd.we_n} <= 3'b111;
      cmd.ba <= ~cmd.ba;
      cmd.addr <= ~cmd.addr;
    end
  endtask : idle

  task automatic send(input logic [3:0] code, input logic [2:0] ba, input logic [13:0] addr);
    @(posedge clk);
    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= code;
    cmd.ba <= ba;
    cmd.addr <= addr;
    idle(1);
  endtask : send

  // Two commands on consecutive edges
  task automatic send_pair(input logic [3:0] c0, input logic [2:0] b0, input logic [13:0] a0,
                           input logic [3:0] c1, input logic [2:0] b1, input logic [13:0] a1);
    @(posedge clk);
    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= c0;
    cmd.ba <= b0;
    cmd.addr <= a0;
    @(posedge clk);
    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= c1;
    cmd.ba <= b1;
    cmd.addr <= a1;
    idle(1);
  endtask : send_pair

  task automatic pins(input logic cke_lvl, input logic odt_lvl);
    @(posedge clk);
    cmd.cke <= cke_lvl;
    cmd.odt <= odt_lvl;
  endtask : pins
endmodule : ddzq_ctrl_model

/* dv/ddzq_dram_bench.sv */
`timescale 1ns/1ns
module ddzq_dram_bench
  import ddzq_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  ddzq_cmd_s cmd;
  ddzq_rdout_s rdout;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int rl = 5;
  logic chk_en = 1'b0;
  logic [7:0] idx;
  logic [7:0] row_of [8];
  logic run_sb [256];
  logic [15:0] dat_sb [256];
  logic [3:0] t_code [6] = '{4'b0101, 4'b0101, 4'b0100, 4'b0100, 4'b0010, 4'b0010};
  int t_sp [6] = '{3, 4, 5, 6, 3, 4};
  int t_bit [6] = '{E_CCD, -1, E_RD2WR, -1, E_RD2PRE, -1};

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  ddzq_ctrl_model ctl_u (.clk(clk), .cmd(cmd));

  ddzq_dram #(.CT_W(8), .PIPE_DEPTH(32)) dut_u (
    .clk(clk), .srst(srst), .cmd(cmd), .rdout(rdout), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk32(reg_rdata, exp);
  endtask : reg_check

  function automatic logic [7:0] elem_of(input logic [2:0] ba, input logic [9:0] col,
                                         input logic bc4, input int k);
    logic [2:0] c;
    c = bc4 ? {col[2], col[1:0] + 2'(k)} : col[2:0] + 3'(k);
    return {ba, col[4:3], c} ^ row_of[ba];
  endfunction : elem_of

  task automatic act(input logic [2:0] ba, input logic [7:0] row);
    ctl_u.send(4'b0011, ba, {6'h00, row});
    row_of[ba] = row;
  endtask : act

  // Expected burst booked at RL after the command cycle
  task automatic book(input logic [2:0] ba, input logic [9:0] col, input logic bc4);
    int t;
    t = cyc + rl;
    for (int k = 0; k < (bc4 ? 2 : 4); k++) begin
      run_sb[8'(t + k)] = 1'b1;
      dat_sb[8'(t + k)] = {elem_of(ba, col, bc4, 2 * k), elem_of(ba, col, bc4, 2 * k + 1)};
    end
  endtask : book

  // Address bit 12 low asks for a chopped burst when chosen per read
  task automatic rd(input logic [2:0] ba, input logic [9:0] col, input logic ap, input logic bc4);
    ctl_u.send(4'b0101, ba, {1'b0, ~bc4, 1'b0, ap, col});
    book(ba, col, bc4);
  endtask : rd

  // Strobe watched every cycle while chk_en is set, data only on booked cycles
  always @(negedge clk) begin
    idx = cyc[7:0];
    if (chk_en) begin
      chk32({29'h0, rdout.dq_oe, rdout.dqs_oe, rdout.dqs_run},
            {29'h0, run_sb[idx], run_sb[idx] | run_sb[idx + 8'h01], run_sb[idx]});
      if (run_sb[idx]) begin
        chk32({16'h0000, rdout.dq_rise, rdout.dq_fall}, {16'h0000, dat_sb[idx]});
      end
    end
    run_sb[idx] = 1'b0;
  end

  always @(posedge clk) begin
    if (cyc == 4000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      run_sb[i] = 1'b0;
    end
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chk_en = 1'b1;
    reg_check(REG_CFG, {18'h0, CFG_RST});
    reg_check(REG_STAT, 32'h0000_0000);
    reg_check(REG_ERR, 32'h0000_0000);
    reg_check(REG_ZQN, 32'h0000_0000);
    reg_check(4'h2, 32'h0000_0000);
    reg_write(REG_STAT, 32'hFFFF_FFFF);
    reg_check(REG_STAT, 32'h0000_0000);
    $display("test registers done");
    act(3'd1, 8'h5A);
    rd(3'd1, 10'h00B, 1'b0, 1'b0);
    ctl_u.idle(2);
    rd(3'd1, 10'h010, 1'b0, 1'b0);
    ctl_u.idle(2);
    rd(3'd1, 10'h3F5, 1'b0, 1'b0);
    ctl_u.idle(12);
    reg_write(REG_CFG, 32'h0000_1505);
    rd(3'd1, 10'h006, 1'b0, 1'b1);
    ctl_u.idle(2);
    rd(3'd1, 10'h00D, 1'b0, 1'b1);
    ctl_u.idle(12);
    reg_write(REG_CFG, 32'h0000_2505);
    rd(3'd1, 10'h013, 1'b0, 1'b1);
    ctl_u.idle(2);
    rd(3'd1, 10'h01C, 1'b0, 1'b0);
    ctl_u.idle(12);
    reg_write(REG_CFG, 32'h0000_0505);
    ctl_u.send(4'b0101, 3'd2, 14'h0000);
    ctl_u.idle(6);
    reg_check(REG_ERR, 32'h1 << E_NOROW);
    reg_write(REG_ERR, 32'h0000_3FFF);
    $display("test bursts done");
    reg_write(REG_CFG, 32'h0000_0525);
    rl = 7;
    row_of[4] = 8'hC3;
    ctl_u.send_pair(4'b0011, 3'd4, 14'h00C3, 4'b0101, 3'd4, 14'h1021);
    book(3'd4, 10'h021, 1'b0);
    ctl_u.idle(14);
    reg_check(REG_ERR, 32'h0000_0000);
    reg_write(REG_CFG, 32'h0000_0505);
    rl = 5;
    row_of[3] = 8'h3C;
    ctl_u.send_pair(4'b0011, 3'd3, 14'h003C, 4'b0101, 3'd3, 14'h1004);
    book(3'd3, 10'h004, 1'b0);
    ctl_u.idle(10);
    reg_check(REG_ERR, 32'h1 << E_RCD);
    reg_write(REG_ERR, 32'h0000_3FFF);
    act(3'd5, 8'h0F);
    ctl_u.idle(2);
    rd(3'd5, 10'h002, 1'b1, 1'b0);
    reg_check(REG_STAT, 32'h0000_023A);
    reg_check(REG_STAT, 32'h0000_023A);
    reg_check(REG_STAT, 32'h0000_001A);
    $display("test auto precharge done");
    chk_en = 1'b0;
    for (int i = 0; i < 6; i++) begin
      act(3'd0, 8'h11);
      ctl_u.send(4'b0101, 3'd0, 14'h0000);
      ctl_u.idle(t_sp[i] - 2);
      ctl_u.send(t_code[i], 3'd0, 14'h0000);
      ctl_u.idle(4);
      reg_check(REG_ERR, (t_bit[i] < 0) ? 32'h0 : 32'h1 << t_bit[i]);
      reg_write(REG_ERR, 32'h0000_3FFF);
      ctl_u.send(4'b0010, 3'd0, 14'h0000);
      ctl_u.idle(8);
    end
    $display("test command spacing done");
    ctl_u.send(4'b0010, 3'd0, 14'h0400);
    ctl_u.idle(12);
    chk_en = 1'b1;
    ctl_u.send(4'b0110, 3'd0, 14'h0400);
    reg_check(REG_STAT, 32'h0000_0100);
    ctl_u.idle(515);
    reg_check(REG_STAT, 32'h0000_0000);
    reg_check(REG_ZQN, 32'h0000_0001);
    ctl_u.send(4'b0110, 3'd0, 14'h0000);
    ctl_u.idle(66);
    reg_check(REG_ZQN, 32'h0000_0002);
    reg_check(REG_ERR, 32'h0000_0000);
    act(3'd6, 8'h77);
    ctl_u.idle(2);
    ctl_u.send(4'b0110, 3'd0, 14'h0000);
    ctl_u.idle(3);
    reg_check(REG_ERR, 32'h1 << E_ZQ_IDLE);
    reg_write(REG_ERR, 32'h0000_3FFF);
    ctl_u.pins(1'b0, 1'b0);
    ctl_u.pins(1'b1, 1'b0);
    ctl_u.idle(1);
    reg_check(REG_ERR, 32'h1 << E_ZQ_CKE);
    reg_write(REG_ERR, 32'h0000_3FFF);
    ctl_u.pins(1'b1, 1'b1);
    ctl_u.pins(1'b1, 1'b0);
    ctl_u.idle(1);
    reg_check(REG_ERR, 32'h1 << E_ZQ_ODT);
    $display("test calibration done");
    give_verdict();
  end
endmodule : ddzq_dram_bench
